// >>> tsc_pkg.sv
// Purpose: Shared constants, types and helpers for the touch status change handshake.
// Assumes: Status inputs come from logic on the same clock as the block.
// Notes:   Setup bytes are stored one byte per location from ADDR_CFG upward.
//
// What this block does
// RQ1 - Any change of sensed status drives the change line low.
// RQ2 - Only status bytes at map locations 2 and 3 are watched.
// RQ3 - Host answers a low change line by reading bytes 2 and 3.
// RQ4 - Change line is released once every changed status byte was read.
// RQ5 - A change during a read still keeps the change line low.
// RQ6 - Change line is open drain, only ever pulled low.
// RQ7 - Mode strap tied low selects host-linked operation over the serial link.
// RQ8 - Host-linked mode serves seven keys and host-writable setup values.
// RQ9 - Standalone mode uses fixed setup, four keys, one pin per key.
// RQ10 - Host writes the pointer, then reads, with standard two-wire framing.
`default_nettype none
package tsc_pkg;

    // ************************************************************
    // Address map and timing
    // ************************************************************
    localparam logic [7:0] ADDR_ID    = 8'h00;
    localparam logic [7:0] ADDR_DET   = 8'h02;
    localparam logic [7:0] ADDR_KEYS  = 8'h03;
    localparam logic [7:0] ADDR_CFG   = 8'h10;
    localparam int         CFG_DEPTH  = 16;
    localparam int         CFG_AW     = 4;
    localparam int         NUM_KEYS   = 7;
    localparam int         SA_KEYS    = 4;
    localparam logic [3:0] BIT_COUNT  = 4'h8;

    // ************************************************************
    // Setup byte positions and reset values
    // ************************************************************
    localparam int CFG_THR_IDX   = 0;
    localparam int CFG_NKS_IDX   = 7;
    localparam int CFG_DI_IDX    = 8;
    localparam int CFG_LP_IDX    = 9;
    localparam int CFG_GUARD_IDX = 10;
    localparam int CFG_MAXON_IDX = 11;
    localparam logic [CFG_DEPTH*8-1:0] CFG_INIT = 128'h00000000_80_00_02_04_00_20202020202020;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic [NUM_KEYS-1:0][7:0] threshold;
        logic [NUM_KEYS-1:0]      neighbour_key_suppression;
        logic [7:0]               detect_integrator;
        logic [7:0]               low_power_setting;
        logic [2:0]               guard_key;
        logic [7:0]               max_on_duration;
    } tsc_cfg_t;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
        ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
    } tsc_state_t;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic in_cfg(input logic [7:0] a);
        in_cfg = (a >= ADDR_CFG) && (a < ADDR_CFG + 8'(CFG_DEPTH));
    endfunction

    function automatic tsc_cfg_t cfg_unpack(input logic [CFG_DEPTH*8-1:0] f);
        tsc_cfg_t c;
        for (int k = 0; k < NUM_KEYS; k++) begin
            c.threshold[k] = f[8*(CFG_THR_IDX+k) +: 8];
        end
        c.neighbour_key_suppression = f[8*CFG_NKS_IDX +: NUM_KEYS];
        c.detect_integrator         = f[8*CFG_DI_IDX +: 8];
        c.low_power_setting         = f[8*CFG_LP_IDX +: 8];
        c.guard_key                 = f[8*CFG_GUARD_IDX +: 3];
        c.max_on_duration           = f[8*CFG_MAXON_IDX +: 8];
        cfg_unpack = c;
    endfunction

endpackage
`default_nettype wire

// >>> tsc_cfg_mem.sv
// Purpose: Storage of the setup bytes with a registered read port.
// Assumes: One write port and one read port on the block clock.
// Notes:   All bytes are also presented flat so that setup fields can steer logic.
`timescale 1ns/10ps
`default_nettype none
module tsc_cfg_mem
    import tsc_pkg::*;
#(
    parameter int                     DEPTH = CFG_DEPTH,
    parameter int                     AW    = CFG_AW,
    parameter logic [DEPTH*8-1:0]     INIT  = CFG_INIT
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 we,
    input  wire logic [AW-1:0]        waddr,
    input  wire logic [7:0]           wdata,
    input  wire logic [AW-1:0]        raddr,
    output var  logic [7:0]           rdata,
    output var  logic [DEPTH*8-1:0]   all_o
);

    logic [DEPTH-1:0][7:0] mem_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_r <= INIT;
        end else if (we) begin
            mem_r[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else begin
            rdata <= mem_r[raddr];
        end
    end

    assign all_o = mem_r;

endmodule
`default_nettype wire

// >>> tsc_change_top.sv
// Purpose: Serial slave with status change notification for a touch key sensor.
// Assumes: The link clock is slow against clk and is sampled, not used as a clock.
// Notes:   The pins are open drain; the enables pull the wires low.
`timescale 1ns/10ps
`default_nettype none
module tsc_change_top
    import tsc_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR  = 7'h2a,
    // The identity value is arbitrary.
    parameter logic [7:0] DEVICE_ID = 8'h5c
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 scl_i,
    input  wire logic                 sda_i,
    output var  logic                 sda_o,
    output var  logic                 sda_oe,
    output var  logic                 change_o,
    output var  logic                 change_oe,
    input  wire logic                 mode_sel_i,
    input  wire logic [7:0]           det_status_i,
    input  wire logic [NUM_KEYS-1:0]  touch_keys,
    output var  logic [SA_KEYS-1:0]   key_report,
    output var  logic                 host_linked,
    output var  tsc_cfg_t             cfg_o
);

    // ************************************************************
    // Reset and input synchronisers
    // ************************************************************
    logic       rst_s1_r, rst_n_r;
    logic [2:0] scl_r, sda_r;
    logic       mode_s1_r, mode_s2_r, cap_done_r, host_linked_r;

    // The strap stages run on the raw reset, so they are full before the capture edge.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_r  <= 1'b0;
            rst_n_r   <= 1'b0;
            mode_s1_r <= 1'b0;
            mode_s2_r <= 1'b0;
        end else begin
            rst_s1_r  <= 1'b1;
            rst_n_r   <= rst_s1_r;
            mode_s1_r <= mode_sel_i;
            mode_s2_r <= mode_s1_r;
        end
    end

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            scl_r <= 3'h7;
            sda_r <= 3'h7;
        end else begin
            scl_r <= {scl_r[1:0], scl_i};
            sda_r <= {sda_r[1:0], sda_i};
        end
    end

    // RQ7 strap capture once.
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cap_done_r    <= 1'b0;
            host_linked_r <= 1'b0;
        end else if (!cap_done_r) begin
            cap_done_r    <= 1'b1;
            host_linked_r <= ~mode_s2_r;
        end
    end

    logic scl_rise_w, scl_fall_w, start_w, stop_w;
    assign scl_rise_w = scl_r[1] & ~scl_r[2];
    assign scl_fall_w = ~scl_r[1] & scl_r[2];
    assign start_w    = scl_r[1] & scl_r[2] & sda_r[2] & ~sda_r[1];
    assign stop_w     = scl_r[1] & scl_r[2] & ~sda_r[2] & sda_r[1];

    // ************************************************************
    // Status bytes and change tracking
    // ************************************************************
    logic [1:0][7:0] stat_w, prev_r;
    logic [1:0]      chg_w, pend_r;
    logic [6:0]      keys_w;
    logic [7:0]      ptr_r, rd_byte_w, mem_rdata_w;
    logic            rd_load_w, wr_en_w;

    // RQ9 standalone four keys.
    assign keys_w    = host_linked_r ? touch_keys : {3'h0, touch_keys[SA_KEYS-1:0]};
    // RQ2 watched bytes two and three.
    assign stat_w[0] = det_status_i;
    assign stat_w[1] = {1'b0, keys_w};

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            prev_r <= 16'h0000;
        end else begin
            prev_r <= stat_w;
        end
    end

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            chg_w[i] = stat_w[i] != prev_r[i];
        end
    end

    // A byte is done when it was loaded for sending; a change in the same cycle wins.
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pend_r <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                // RQ1 RQ4 RQ5 pending per byte.
                pend_r[i] <= chg_w[i] |
                             (pend_r[i] & ~(rd_load_w && ptr_r == ADDR_DET + 8'(i)));
            end
        end
    end

    // RQ6 open drain pins.
    assign change_o  = 1'b0;
    assign change_oe = |pend_r;
    assign sda_o     = 1'b0;

    // ************************************************************
    // Read data select
    // ************************************************************
    always_comb begin
        if (ptr_r == ADDR_ID) begin
            rd_byte_w = DEVICE_ID;
        end else if (ptr_r == ADDR_DET) begin
            rd_byte_w = stat_w[0];
        end else if (ptr_r == ADDR_KEYS) begin
            rd_byte_w = stat_w[1];
        end else if (in_cfg(ptr_r)) begin
            rd_byte_w = mem_rdata_w;
        end else begin
            rd_byte_w = 8'h00;
        end
    end

    // ************************************************************
    // Serial slave
    // ************************************************************
    tsc_state_t  state_r;
    logic [3:0]  cnt_r;
    logic [7:0]  sh_r, tx_r;
    logic        rw_r, mack_r, sda_oe_r;

    assign sda_oe    = sda_oe_r;
    assign rd_load_w = scl_fall_w && ((state_r == ST_ADDR_ACK && rw_r) ||
                                      (state_r == ST_RACK && !mack_r));
    // RQ7 RQ8 writes only when host-linked.
    assign wr_en_w   = scl_fall_w && state_r == ST_WDATA && cnt_r == BIT_COUNT &&
                       host_linked_r && in_cfg(ptr_r);

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r  <= ST_IDLE;
            cnt_r    <= 4'h0;
            sh_r     <= 8'h00;
            tx_r     <= 8'h00;
            ptr_r    <= 8'h00;
            rw_r     <= 1'b0;
            mack_r   <= 1'b1;
            sda_oe_r <= 1'b0;
        end else if (stop_w) begin
            state_r  <= ST_IDLE;
            sda_oe_r <= 1'b0;
        end else if (start_w) begin
            state_r  <= ST_ADDR;
            cnt_r    <= 4'h0;
            sda_oe_r <= 1'b0;
        end else if (scl_rise_w) begin
            sh_r <= {sh_r[6:0], sda_r[1]};
            if (state_r == ST_RACK) begin
                mack_r <= sda_r[1];
            end else if (state_r != ST_IDLE && cnt_r != BIT_COUNT) begin
                cnt_r <= cnt_r + 4'h1;
            end
        end else if (scl_fall_w) begin
            case (state_r)
                ST_ADDR: begin
                    if (cnt_r == BIT_COUNT) begin
                        cnt_r <= 4'h0;
                        if (sh_r[7:1] == DEV_ADDR) begin
                            rw_r     <= sh_r[0];
                            sda_oe_r <= 1'b1;
                            state_r  <= ST_ADDR_ACK;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                ST_PTR: begin
                    if (cnt_r == BIT_COUNT) begin
                        ptr_r    <= sh_r;
                        sda_oe_r <= 1'b1;
                        state_r  <= ST_PTR_ACK;
                    end
                end
                ST_WDATA: begin
                    if (cnt_r == BIT_COUNT) begin
                        ptr_r    <= ptr_r + 8'h01;
                        sda_oe_r <= 1'b1;
                        state_r  <= ST_WACK;
                    end
                end
                ST_ADDR_ACK, ST_RACK: begin
                    cnt_r <= 4'h0;
                    if (rd_load_w) begin
                        tx_r     <= rd_byte_w;
                        ptr_r    <= ptr_r + 8'h01;
                        sda_oe_r <= ~rd_byte_w[7];
                        state_r  <= ST_RDATA;
                    end else begin
                        sda_oe_r <= 1'b0;
                        state_r  <= (state_r == ST_ADDR_ACK) ? ST_PTR : ST_IDLE;
                    end
                end
                ST_PTR_ACK, ST_WACK: begin
                    cnt_r    <= 4'h0;
                    sda_oe_r <= 1'b0;
                    state_r  <= ST_WDATA;
                end
                ST_RDATA: begin
                    if (cnt_r == BIT_COUNT) begin
                        sda_oe_r <= 1'b0;
                        mack_r   <= 1'b1;
                        state_r  <= ST_RACK;
                    end else begin
                        sda_oe_r <= ~tx_r[6];
                        tx_r     <= {tx_r[6:0], 1'b0};
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Setup storage and outputs
    // ************************************************************
    logic [CFG_DEPTH*8-1:0] cfg_all_w;

    tsc_cfg_mem #(
        .DEPTH (CFG_DEPTH),
        .AW    (CFG_AW),
        .INIT  (CFG_INIT)
    ) u_mem (
        .clk   (clk),
        .rst_n (rst_n_r),
        .we    (wr_en_w),
        .waddr (CFG_AW'(ptr_r - ADDR_CFG)),
        .wdata (sh_r),
        .raddr (CFG_AW'(ptr_r - ADDR_CFG)),
        .rdata (mem_rdata_w),
        .all_o (cfg_all_w)
    );

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cfg_o      <= cfg_unpack(CFG_INIT);
            key_report <= 4'h0;
        end else begin
            // RQ8 RQ9 setup source by mode.
            cfg_o      <= host_linked_r ? cfg_unpack(cfg_all_w) : cfg_unpack(CFG_INIT);
            key_report <= host_linked_r ? 4'h0 : touch_keys[SA_KEYS-1:0];
        end
    end

    assign host_linked = host_linked_r;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_r);

    chk_change_asserts: assert property (|chg_w |=> change_oe) // RQ1
        else $error("Status change did not pull the change line.");
    chk_monitored_bytes: assert property ($rose(change_oe) |-> $past(|chg_w)) // RQ2
        else $error("Change line fell without a watched byte change.");
    chk_release_read: assert property ($fell(change_oe) |-> $past(rd_load_w)) // RQ4
        else $error("Change line released without a status read.");
    chk_read_change: assert property ((rd_load_w && |chg_w) |=> change_oe [*2]) // RQ5
        else $error("Change during a read was lost.");
    chk_open_drain: assert property (!change_o && !sda_o) // RQ6
        else $error("Open drain pin driven high.");
    chk_write_mode: assert property (wr_en_w |-> host_linked_r && cap_done_r) // RQ7
        else $error("Setup written outside host-linked mode.");
    chk_host_cfg: assert property (host_linked_r && $stable(host_linked_r)
                                   |=> cfg_o == cfg_unpack($past(cfg_all_w))) // RQ8
        else $error("Setup output does not follow stored bytes.");
    chk_sa_cfg: assert property (!host_linked_r |=> cfg_o == cfg_unpack(CFG_INIT)) // RQ9
        else $error("Standalone setup is not fixed.");
    chk_sa_keys: assert property ((!host_linked_r && cap_done_r)
                                  |=> key_report == $past(touch_keys[SA_KEYS-1:0])
                                      && stat_w[1][6:4] == 3'h0) // RQ9
        else $error("Standalone key pins wrong.");

    cov_change_cycle: cover property ($rose(change_oe) ##[1:1000] $fell(change_oe));
    cov_read_load: cover property (rd_load_w && ptr_r == ADDR_KEYS);
    cov_write: cover property (wr_en_w);
    cov_standalone: cover property (cap_done_r && !host_linked_r && |chg_w);

endmodule
`default_nettype wire

// >>> tsc_host_model.sv
// Purpose: Behavioural two-wire master standing in for the host controller.
// Assumes: Wires are resolved by the bench; enables high pull the wire low.
// Notes:   Clock stretching is not honoured, which the device never uses.
`timescale 1ns/10ps
`default_nettype none
module tsc_host_model #(
    parameter int Q = 5
) (
    input  wire logic clk,
    input  wire logic sda,
    output var  logic scl_oe,
    output var  logic sda_oe
);
    logic busy;

    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
        busy   = 1'b0;
    end

    task automatic tick();
        repeat (Q) @(posedge clk);
    endtask

    task automatic start();
        if (busy) begin
            scl_oe <= 1'b1;
            tick();
            sda_oe <= 1'b0;
            tick();
            scl_oe <= 1'b0;
            tick();
        end
        sda_oe <= 1'b1;
        tick();
        busy = 1'b1;
    endtask

    task automatic stop();
        scl_oe <= 1'b1;
        tick();
        sda_oe <= 1'b1;
        tick();
        scl_oe <= 1'b0;
        tick();
        sda_oe <= 1'b0;
        tick();
        busy = 1'b0;
    endtask

    // Data is set while the clock is low and sampled mid high phase.
    task automatic bit_io(input logic b, output logic r);
        scl_oe <= 1'b1;
        tick();
        sda_oe <= ~b;
        tick();
        scl_oe <= 1'b0;
        tick();
        r = sda;
        tick();
    endtask

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(last, r);
    endtask
endmodule
`default_nettype wire

// >>> touch_status_change_handshake_bench.sv
// Purpose: Self-checking bench for the change line and serial slave.
// Assumes: Pull-ups on both serial wires and on the change line.
// Notes:   A wire released by all parties reads high.
`timescale 1ns/10ps
`default_nettype none
module touch_status_change_handshake_bench
    import tsc_pkg::*;
;
    localparam logic [6:0] DEV = 7'h2a;
    // The identity value is arbitrary.
    localparam logic [7:0] ID  = 8'h5c;

    logic                clk;
    logic                rst_n;
    logic                mode_sel_i;
    logic [7:0]          det_status_i;
    logic [NUM_KEYS-1:0] touch_keys;
    logic                scl_oe_h;
    logic                sda_oe_h;
    logic                sda_o;
    logic                sda_oe;
    logic                change_o;
    logic                change_oe;
    logic [SA_KEYS-1:0]  key_report;
    logic                host_linked;
    tsc_cfg_t            cfg_o;
    wire logic           scl_w    = ~scl_oe_h;
    wire logic           sda_w    = (sda_oe ? sda_o : 1'b1) & ~sda_oe_h;
    wire logic           change_w = change_oe ? change_o : 1'b1;
    int                  failures = 0;
    int                  tests_run = 0;

    tsc_change_top #(.DEV_ADDR(DEV), .DEVICE_ID(ID)) dut (
        .clk(clk), .rst_n(rst_n), .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe(sda_oe), .change_o(change_o), .change_oe(change_oe),
        .mode_sel_i(mode_sel_i), .det_status_i(det_status_i), .touch_keys(touch_keys),
        .key_report(key_report), .host_linked(host_linked), .cfg_o(cfg_o)
    );

    tsc_host_model h (.clk(clk), .sda(sda_w), .scl_oe(scl_oe_h), .sda_oe(sda_oe_h));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("tests_run %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic open_rd(input logic [7:0] ptr);
        logic a;
        h.start();
        h.send_byte({DEV, 1'b0}, a);
        check(a, 1'b1);
        h.send_byte(ptr, a);
        check(a, 1'b1);
        h.start();
        h.send_byte({DEV, 1'b1}, a);
        check(a, 1'b1);
    endtask

    task automatic read_one(input logic [7:0] ptr, input logic [7:0] e);
        logic [7:0] d;
        open_rd(ptr);
        h.recv_byte(1'b1, d);
        check(d, e);
        h.stop();
    endtask

    task automatic read_pair(input logic [7:0] e2, input logic [7:0] e3, input logic mid);
        logic [7:0] d;
        int         n;
        n = 0;
        while (change_w !== 1'b0 && n < 50) begin
            @(posedge clk);
            n++;
        end
        check(change_w, 1'b0);
        open_rd(ADDR_DET);
        h.recv_byte(1'b0, d);
        check(d, e2);
        // The device sees the clock fall two cycles late, so this change meets the load.
        fork
            h.recv_byte(1'b1, d);
            if (mid) begin
                repeat (2) @(posedge clk);
                det_status_i <= ~e2;
            end
        join
        check(d, e3);
        h.stop();
        @(negedge clk);
        check(change_oe, mid);
        @(posedge clk);
    endtask

    task automatic do_reset(input logic mode);
        rst_n      <= 1'b0;
        mode_sel_i <= mode;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (12) @(posedge clk);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset_state();
        @(negedge clk);
        check(host_linked, 1'b1);
        check({sda_oe, change_oe, key_report}, 6'h00);
        check({sda_o, change_o}, 2'h0);
    endtask

    task automatic t_refused();
        logic a;
        h.start();
        h.send_byte({7'h2b, 1'b1}, a);
        check(a, 1'b0);
        h.stop();
        read_one(ADDR_ID, ID);
    endtask

    task automatic t_setup();
        logic a;
        h.start();
        h.send_byte({DEV, 1'b0}, a);
        h.send_byte(ADDR_CFG, a);
        for (int k = 0; k < 12; k++) begin
            h.send_byte(8'h31 + 8'(k), a);
            check(a, 1'b1);
        end
        h.stop();
        for (int k = 0; k < NUM_KEYS; k++) begin
            check(cfg_o.threshold[k], 8'h31 + 8'(k));
        end
        check(cfg_o.neighbour_key_suppression, 7'h38);
        check({cfg_o.detect_integrator, cfg_o.low_power_setting}, 16'h393a);
        check({cfg_o.guard_key, cfg_o.max_on_duration}, 11'h33c);
        check(change_oe, 1'b0);
    endtask

    task automatic t_change_reads();
        touch_keys <= 7'h7f;
        @(negedge clk);
        check(change_oe, 1'b0);
        @(negedge clk);
        check(change_oe, 1'b1);
        check(key_report, 4'h0);
        read_pair(8'h00, 8'h7f, 1'b0);
        det_status_i <= 8'ha5;
        read_pair(8'ha5, 8'h7f, 1'b1);
        read_pair(8'h5a, 8'h7f, 1'b0);
        touch_keys <= 7'h01;
        repeat (3) @(posedge clk);
        check(change_oe, 1'b1);
        read_one(ADDR_KEYS, 8'h01);
        @(negedge clk);
        check(change_oe, 1'b0);
        @(posedge clk);
    endtask

    task automatic t_standalone();
        logic a;
        do_reset(1'b1);
        check(host_linked, 1'b0);
        check({cfg_o.threshold[0], cfg_o.max_on_duration}, 16'h2080);
        touch_keys <= 7'h7a;
        @(posedge clk);
        @(negedge clk);
        check(key_report, 4'ha);
        h.start();
        h.send_byte({DEV, 1'b0}, a);
        h.send_byte(ADDR_CFG, a);
        h.send_byte(8'h55, a);
        h.stop();
        check(cfg_o.threshold[0], 8'h20);
        read_one(ADDR_KEYS, 8'h0a);
    endtask

    // ************************************************************
    // Clock, sequence and watchdog
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        rst_n        = 1'b0;
        mode_sel_i   = 1'b0;
        det_status_i = 8'h00;
        touch_keys   = 7'h00;
        do_reset(1'b0);
        t_reset_state();
        t_refused();
        t_setup();
        t_change_reads();
        t_standalone();
        give_verdict();
    end

    // The whole run needs about 8500 cycles; this leaves a wide margin.
    initial begin
        repeat (40000) @(posedge clk);
        failures++;
        give_verdict();
    end
endmodule
`default_nettype wire
